// file: logic/cbi_top.sv
/*
 Control bus command interface with its program interface: decodes bridge
 commands into single and burst accesses on the sensing chip control bus,
 keeps the interface and interrupt-handling enables, and launches fixed
 writes on interrupt edges.
 Assumes bridge strobes are one-cycle pulses synchronous to clk_sys, the
 host-to-board FIFO shows its head word while not empty, and all pins are
 synchronous to clk_sys.
*/
// How it works
// - Write at 0x0zz performs one bus write to register zz.
// - Single write data is the low 16 bits of the bridge word.
// - Read at 0x0zz reads register zz and returns it on the bridge.
// - Burst write starts at zz and steps the address after each word.
// - Write at 0x1zz starts a burst write from FIFO, data ignored.
// - Nibble 4, 8, c reads 16, 64, 128 registers from zz.
// - Read-burst words go into the board-to-host FIFO.
// - Any write to 0x400 pulses the configuration trigger.
// - Either interrupt request launches a fixed bus write by itself.
// - Program write at 0x000 sets host and front-end enables.
// - An enable changes only when its mask bit is one.
// - Program write at 0x100 sets gain and processor interrupt enables.
// - Enabled gain interrupt rising edge gives a two-cycle request pulse.
// - Bridge has 12-bit address, split 32-bit data, read/write strobes.
// - Ready acknowledges each taken transaction for one cycle.
// - Device drives bus address and enable; data bus is two-way.
`timescale 1ns/1ps
module cbi_top import cbi_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Command bridge
   input wire cbi_req_t cmd_req,
   output logic [31:0] cmd_rdata,
   output logic cmd_ready,
   // Program bridge
   input wire cbi_req_t prg_req,
   output logic [31:0] prg_rdata,
   output logic prg_ready,
   // Host-to-board FIFO
   input wire logic [31:0] h2b_data,
   input wire logic h2b_empty,
   output logic h2b_rd,
   // Board-to-host FIFO
   output logic [31:0] b2h_data,
   input wire logic b2h_full,
   output logic b2h_wr,
   // Control bus
   output cbi_bus_t cb_out,
   input wire logic [15:0] cb_din,
   // Enables, trigger and interrupt pins
   output logic host_if_en,
   output logic fe_if_en,
   output logic fire_config,
   input wire logic agc_irq_pin,
   input wire logic sp_irq_pin
);
   function automatic logic [7:0] read_len(input logic [3:0] nib);
      unique case (nib)
         NIB_RD16: read_len = LEN_RD16;
         NIB_RD64: read_len = LEN_RD64;
         NIB_RD128: read_len = LEN_RD128;
         default: read_len = 8'h00;
      endcase
   endfunction : read_len

   function automatic logic masked(input logic old, input logic val, input logic msk);
      masked = msk ? val : old;
   endfunction : masked

   cbi_state_t state_reg;
   logic [7:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] cap_reg;
   logic [7:0] rem_reg;
   logic burst_reg;
   logic rburst_reg;
   logic cmd_ready_reg;
   logic [31:0] cmd_rdata_reg;
   logic fire_reg;
   logic host_en_reg;
   logic fe_en_reg;
   logic agc_en_reg;
   logic sp_en_reg;
   logic prg_ready_reg;
   logic agc_prev_reg;
   logic sp_prev_reg;
   logic [1:0] agc_cnt_reg;
   logic [1:0] sp_cnt_reg;
   logic agc_req_prev_reg;
   logic sp_req_prev_reg;
   logic agc_pend_reg;
   logic sp_pend_reg;
   logic agc_req;
   logic sp_req;
   logic [3:0] nib;
   logic take_cmd;
   logic take_irq;
   logic buf_in_ready;
   logic buf_in_valid;
   logic buf_out_valid;
   logic [15:0] buf_out_data;

   assign nib = cmd_req.addr[CMD_NIB_HI:CMD_NIB_LO];
   // Host commands win; interrupt writes wait as pending flags
   assign take_cmd = (state_reg == ST_IDLE) && (cmd_req.rd || cmd_req.wr);
   assign take_irq = (state_reg == ST_IDLE) && !take_cmd && (agc_pend_reg || sp_pend_reg);

   assign cmd_ready = cmd_ready_reg;
   assign cmd_rdata = cmd_rdata_reg;
   assign prg_ready = prg_ready_reg;
   assign prg_rdata = {28'h000_0000, sp_en_reg, agc_en_reg, fe_en_reg, host_en_reg};
   assign fire_config = fire_reg;
   assign host_if_en = host_en_reg;
   assign fe_if_en = fe_en_reg;

   // Bus driven only by this device; data drive only during writes
   assign cb_out.en = (state_reg == ST_WR) || (state_reg == ST_RD);
   assign cb_out.oe = (state_reg == ST_WR);
   assign cb_out.addr = addr_reg;
   assign cb_out.dout = wdata_reg;

   // Pop head word when a burst write takes it
   assign h2b_rd = (state_reg == ST_BW) && !h2b_empty;
   assign buf_in_valid = (state_reg == ST_PUSH);
   assign b2h_wr = buf_out_valid && !b2h_full;
   assign b2h_data = {16'h0000, buf_out_data};

   // Command sequencer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         addr_reg <= 8'h00;
         wdata_reg <= 16'h0000;
         rem_reg <= 8'h00;
         burst_reg <= 1'b0;
         rburst_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (take_cmd && cmd_req.wr && nib == NIB_SINGLE) begin
                  addr_reg <= cmd_req.addr[7:0];
                  wdata_reg <= cmd_req.wdata[15:0];
                  burst_reg <= 1'b0;
                  state_reg <= ST_WR;
               end else if (take_cmd && cmd_req.wr && nib == NIB_BURST_WR) begin
                  addr_reg <= cmd_req.addr[7:0];
                  burst_reg <= 1'b1;
                  state_reg <= ST_BW;
               end else if (take_cmd && cmd_req.rd && nib == NIB_SINGLE) begin
                  addr_reg <= cmd_req.addr[7:0];
                  rburst_reg <= 1'b0;
                  state_reg <= ST_RD;
               end else if (take_cmd && cmd_req.rd && read_len(nib) != 8'h00) begin
                  addr_reg <= cmd_req.addr[7:0];
                  rem_reg <= read_len(nib);
                  rburst_reg <= 1'b1;
                  state_reg <= ST_RD;
               end else if (take_irq) begin
                  addr_reg <= agc_pend_reg ? IRQ_AGC_ADDR : IRQ_SP_ADDR;
                  wdata_reg <= agc_pend_reg ? IRQ_AGC_DATA : IRQ_SP_DATA;
                  burst_reg <= 1'b0;
                  state_reg <= ST_WR;
               end
            end
            ST_WR: begin
               if (burst_reg) begin
                  addr_reg <= addr_reg + 8'h01;
                  state_reg <= ST_BW;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_BW: begin
               // Burst write ends when the preloaded FIFO runs dry
               if (h2b_empty) begin
                  burst_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  wdata_reg <= h2b_data[15:0];
                  state_reg <= ST_WR;
               end
            end
            ST_RD: state_reg <= ST_CAP;
            ST_CAP: state_reg <= rburst_reg ? ST_PUSH : ST_IDLE;
            ST_PUSH: begin
               if (buf_in_ready) begin
                  addr_reg <= addr_reg + 8'h01;
                  rem_reg <= rem_reg - 8'h01;
                  state_reg <= (rem_reg == 8'h01) ? ST_IDLE : ST_RD;
               end
            end
         endcase
      end
   end

   // Read capture one cycle after the enable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cap_reg <= 16'h0000;
      end else if (state_reg == ST_CAP) begin
         cap_reg <= cb_din;
      end
   end

   // Command acknowledge and single-read return
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmd_ready_reg <= 1'b0;
         cmd_rdata_reg <= 32'h0000_0000;
      end else begin
         cmd_ready_reg <= 1'b0;
         if (take_cmd && (cmd_req.wr || nib != NIB_SINGLE)) begin
            cmd_ready_reg <= 1'b1;
         end
         if (state_reg == ST_CAP && !rburst_reg) begin
            cmd_rdata_reg <= {16'h0000, cb_din};
            cmd_ready_reg <= 1'b1;
         end
      end
   end

   // Configuration trigger
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fire_reg <= 1'b0;
      end else begin
         fire_reg <= take_cmd && cmd_req.wr && cmd_req.addr == FIRE_ADDR;
      end
   end

   // Program interface enables
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         host_en_reg <= RST_ENABLE;
         fe_en_reg <= RST_ENABLE;
         agc_en_reg <= RST_ENABLE;
         sp_en_reg <= RST_ENABLE;
         prg_ready_reg <= 1'b0;
      end else begin
         prg_ready_reg <= prg_req.wr || prg_req.rd;
         if (prg_req.wr && prg_req.addr == OFS_IF_ENABLE) begin
            host_en_reg <= masked(host_en_reg, prg_req.wdata[BIT_LO_VAL],
                                  prg_req.wdata[BIT_LO_MSK]);
            fe_en_reg <= masked(fe_en_reg, prg_req.wdata[BIT_HI_VAL],
                                prg_req.wdata[BIT_HI_MSK]);
         end
         if (prg_req.wr && prg_req.addr == OFS_IRQ_ENABLE) begin
            agc_en_reg <= masked(agc_en_reg, prg_req.wdata[BIT_LO_VAL],
                                 prg_req.wdata[BIT_LO_MSK]);
            sp_en_reg <= masked(sp_en_reg, prg_req.wdata[BIT_HI_VAL],
                                prg_req.wdata[BIT_HI_MSK]);
         end
      end
   end

   // Interrupt edge detection and two-cycle request pulses
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         agc_prev_reg <= 1'b0;
         sp_prev_reg <= 1'b0;
         agc_cnt_reg <= 2'd0;
         sp_cnt_reg <= 2'd0;
      end else begin
         agc_prev_reg <= agc_irq_pin;
         sp_prev_reg <= sp_irq_pin;
         if (agc_en_reg && agc_irq_pin && !agc_prev_reg) begin
            agc_cnt_reg <= 2'(IRQ_PULSE_CYC);
         end else if (agc_cnt_reg != 2'd0) begin
            agc_cnt_reg <= agc_cnt_reg - 2'd1;
         end
         if (sp_en_reg && sp_irq_pin && !sp_prev_reg) begin
            sp_cnt_reg <= 2'(IRQ_PULSE_CYC);
         end else if (sp_cnt_reg != 2'd0) begin
            sp_cnt_reg <= sp_cnt_reg - 2'd1;
         end
      end
   end

   assign agc_req = (agc_cnt_reg != 2'd0);
   assign sp_req = (sp_cnt_reg != 2'd0);

   // Pending interrupt writes; a new request wins over the clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         agc_req_prev_reg <= 1'b0;
         sp_req_prev_reg <= 1'b0;
         agc_pend_reg <= 1'b0;
         sp_pend_reg <= 1'b0;
      end else begin
         agc_req_prev_reg <= agc_req;
         sp_req_prev_reg <= sp_req;
         if (agc_req && !agc_req_prev_reg) begin
            agc_pend_reg <= 1'b1;
         end else if (take_irq && agc_pend_reg) begin
            agc_pend_reg <= 1'b0;
         end
         if (sp_req && !sp_req_prev_reg) begin
            sp_pend_reg <= 1'b1;
         end else if (take_irq && !agc_pend_reg) begin
            sp_pend_reg <= 1'b0;
         end
      end
   end

   cbi_buf2 u_buf (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(cap_reg),
      .out_valid(buf_out_valid),
      .out_ready(!b2h_full),
      .out_data(buf_out_data)
   );

   a_ready_one_cycle: assert property (
      @(posedge clk_sys) disable iff (!resetn) cmd_ready |=> !cmd_ready)
      else $error("command ready longer than one cycle");

   a_single_write: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      take_cmd && cmd_req.wr && nib == NIB_SINGLE |=> cb_out.en && cb_out.oe
      && cb_out.addr == $past(cmd_req.addr[7:0]) && cb_out.dout == $past(cmd_req.wdata[15:0]))
      else $error("single write not driven on bus");

   a_single_read: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      take_cmd && cmd_req.rd && nib == NIB_SINGLE |=> cb_out.en && !cb_out.oe ##2 cmd_ready)
      else $error("single read not returned in time");

   a_burst_step: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_WR && burst_reg |=> addr_reg == $past(addr_reg) + 8'h01)
      else $error("burst address did not step");

   a_rd_len: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      take_cmd && cmd_req.rd && nib == NIB_RD64 |=> rem_reg == LEN_RD64)
      else $error("read burst length wrong");

   a_fire_pulse: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      take_cmd && cmd_req.wr && cmd_req.addr == FIRE_ADDR |=> fire_config ##1 !fire_config)
      else $error("trigger pulse wrong");

   a_en_hold: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      prg_req.wr && prg_req.addr == OFS_IF_ENABLE && !prg_req.wdata[BIT_LO_MSK]
      |=> $stable(host_if_en))
      else $error("host enable changed without mask");

   a_agc_pulse: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      agc_en_reg && $rose(agc_irq_pin) |=> agc_req [*2])
      else $error("gain request pulse not two cycles");

   a_sp_pulse: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      sp_en_reg && $rose(sp_irq_pin) |=> sp_req [*2])
      else $error("processor request pulse not two cycles");

   a_irq_launch: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      take_irq && agc_pend_reg |=> cb_out.en && cb_out.oe && cb_out.addr == IRQ_AGC_ADDR)
      else $error("interrupt write not launched");
endmodule : cbi_top

// file: logic/cbi_pkg.sv
/*
 Package for the control bus command interface: bridge and bus carriers,
 command decode constants, program-interface offsets and timing counts.
 Assumes a single 10 MHz system clock shared by all users.
*/
package cbi_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int IRQ_PULSE_CYC = 2;
   localparam int RD_LAT_CYC = 1;

   // Command address fields
   localparam int CMD_NIB_HI = 11;
   localparam int CMD_NIB_LO = 8;
   localparam logic [3:0] NIB_SINGLE = 4'h0;
   localparam logic [3:0] NIB_BURST_WR = 4'h1;
   localparam logic [3:0] NIB_FIRE = 4'h4;
   localparam logic [3:0] NIB_RD16 = 4'h4;
   localparam logic [3:0] NIB_RD64 = 4'h8;
   localparam logic [3:0] NIB_RD128 = 4'hc;
   localparam logic [11:0] FIRE_ADDR = 12'h400;
   localparam logic [7:0] LEN_RD16 = 8'h10;
   localparam logic [7:0] LEN_RD64 = 8'h40;
   localparam logic [7:0] LEN_RD128 = 8'h80;

   // Program interface registers
   localparam logic [11:0] OFS_IF_ENABLE = 12'h000;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h100;
   localparam int BIT_LO_VAL = 0;
   localparam int BIT_LO_MSK = 1;
   localparam int BIT_HI_VAL = 2;
   localparam int BIT_HI_MSK = 3;
   localparam logic RST_ENABLE = 1'b0;

   // Predefined writes launched by the interrupt requests
   localparam logic [7:0] IRQ_AGC_ADDR = 8'h00;
   localparam logic [15:0] IRQ_AGC_DATA = 16'h0000;
   localparam logic [7:0] IRQ_SP_ADDR = 8'h01;
   localparam logic [15:0] IRQ_SP_DATA = 16'h0000;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } cbi_req_t;

   typedef struct packed {
      logic en;
      logic oe;
      logic [7:0] addr;
      logic [15:0] dout;
   } cbi_bus_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_WR = 6'b00_0010,
      ST_BW = 6'b00_0100,
      ST_RD = 6'b00_1000,
      ST_CAP = 6'b01_0000,
      ST_PUSH = 6'b10_0000
   } cbi_state_t;
endpackage : cbi_pkg

// file: logic/cbi_buf2.sv
/*
 Two-entry buffer with valid/ready on both sides for read-burst words.
 Assumes the drain side may stall at any time; nothing is dropped.
*/
`timescale 1ns/1ps
module cbi_buf2 import cbi_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [15:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [15:0] out_data
);
   logic [15:0] mem_reg [2];
   logic wp_reg;
   logic rp_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = (cnt_reg != 2'd2);
   assign out_valid = (cnt_reg != 2'd0);
   assign out_data = mem_reg[rp_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'd0;
      end else begin
         if (push) wp_reg <= ~wp_reg;
         if (pop) rp_reg <= ~rp_reg;
         cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) mem_reg[wp_reg] <= in_data;
   end

   a_buf_no_over: assert property (@(posedge clk_sys) disable iff (!resetn)
      cnt_reg == 2'd2 && !pop |=> cnt_reg == 2'd2) else $error("buffer lost an entry");
endmodule : cbi_buf2

// file: dv/cbi_far_model.sv
/*
 Far-side model: register file of the sensing chip on the control bus,
 plus the host-to-board and board-to-host FIFOs of the bridge.
 Assumes the bench preloads mem and h2bq through hierarchy.
*/
`timescale 1ns/1ps
module cbi_far_model import cbi_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Control bus
   input wire cbi_bus_t cb_out,
   output logic [15:0] cb_din,
   // FIFOs
   output logic [31:0] h2b_data,
   output logic h2b_empty,
   input wire logic h2b_rd,
   input wire logic [31:0] b2h_data,
   output logic b2h_full,
   input wire logic b2h_wr,
   input wire logic slow
);
   logic [15:0] mem [256];
   logic [23:0] wlog [$];
   logic [31:0] h2bq [$];
   logic [31:0] b2hq [$];
   logic [1:0] cnt;
   logic [31:0] junk;
   initial begin
      cb_din = 16'h0000;
      cnt = 2'd0;
      junk = 32'h5a5a_5a5a;
      b2h_full = 1'b0;
      h2b_empty = 1'b1;
      h2b_data = 32'h0000_0000;
   end
   // Read data holds one cycle only, then shows its inverse
   always @(posedge clk_sys) begin
      if (cb_out.en && !cb_out.oe) begin
         cb_din <= mem[cb_out.addr];
      end else begin
         cb_din <= ~cb_din;
      end
      if (cb_out.en && cb_out.oe) begin
         mem[cb_out.addr] <= cb_out.dout;
         wlog.push_back({cb_out.addr, cb_out.dout});
      end
      if (h2b_rd && h2bq.size() > 0) begin
         void'(h2bq.pop_front());
      end
      if (b2h_wr && !b2h_full) begin
         b2hq.push_back(b2h_data);
      end
      cnt <= cnt + 2'd1;
      junk <= ~junk;
      // Slow host: full three cycles out of four
      b2h_full <= slow && (cnt != 2'd0);
   end
   // Show-ahead head word; garbage while empty
   always @(negedge clk_sys) begin
      h2b_empty <= (h2bq.size() == 0);
      h2b_data <= (h2bq.size() == 0) ? junk : h2bq[0];
   end
endmodule : cbi_far_model

// file: dv/tb_top.sv
/*
 Self-checking bench for cbi_top against a queue-based model.
 Assumes cbi_far_model stands on the control bus and FIFO ports.
*/
`timescale 1ns/1ps
module tb_top;
   import cbi_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   cbi_req_t cmd_req = '0;
   cbi_req_t prg_req = '0;
   logic [31:0] cmd_rdata, prg_rdata, h2b_data, b2h_data;
   logic cmd_ready, prg_ready, h2b_empty, h2b_rd, b2h_full, b2h_wr;
   cbi_bus_t cb_out;
   logic [15:0] cb_din;
   logic host_if_en, fe_if_en, fire_config;
   logic agc_irq_pin = 1'b0;
   logic sp_irq_pin = 1'b0;
   logic slow = 1'b0;
   int err_total, checked, rdy_n, prdy_n, fire_n;
   logic [15:0] mdl [256];
   logic [23:0] expq [$];
   logic [3:0] en_m;
   always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   cbi_top i_cbi_top (.clk_sys(clk_sys), .resetn(resetn), .cmd_req(cmd_req),
      .cmd_rdata(cmd_rdata), .cmd_ready(cmd_ready), .prg_req(prg_req),
      .prg_rdata(prg_rdata), .prg_ready(prg_ready), .h2b_data(h2b_data),
      .h2b_empty(h2b_empty), .h2b_rd(h2b_rd), .b2h_data(b2h_data),
      .b2h_full(b2h_full), .b2h_wr(b2h_wr), .cb_out(cb_out), .cb_din(cb_din),
      .host_if_en(host_if_en), .fe_if_en(fe_if_en), .fire_config(fire_config),
      .agc_irq_pin(agc_irq_pin), .sp_irq_pin(sp_irq_pin));
   cbi_far_model i_cbi_far_model (.clk_sys(clk_sys), .resetn(resetn),
      .cb_out(cb_out), .cb_din(cb_din), .h2b_data(h2b_data),
      .h2b_empty(h2b_empty), .h2b_rd(h2b_rd), .b2h_data(b2h_data),
      .b2h_full(b2h_full), .b2h_wr(b2h_wr), .slow(slow));
   // Count cycles each pulse output stands high
   always @(posedge clk_sys) begin
      if (cmd_ready === 1'b1) rdy_n++;
      if (prg_ready === 1'b1) prdy_n++;
      if (fire_config === 1'b1) fire_n++;
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic conclude;
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // Wait until the bus and the read path have been quiet for 8 cycles;
   // a stalling host still leaves two pop chances in that span
   task automatic settle;
      int q, n;
      q = 0;
      for (n = 0; n < 4000 && q < 8; n++) begin
         @(posedge clk_sys);
         q = (cb_out.en === 1'b0 && b2h_wr === 1'b0) ? q + 1 : 0;
      end
      if (q < 8) check("settle", 0, 1);
   endtask : settle
   task automatic cmd(logic rd, logic wr, logic [11:0] a, logic [31:0] d);
      int r0;
      r0 = rdy_n;
      @(posedge clk_sys);
      #1 cmd_req = '{rd, wr, a, d};
      @(posedge clk_sys);
      #1 cmd_req.rd = 1'b0;
      cmd_req.wr = 1'b0;
      settle();
      check("cmd_ready", rdy_n - r0, 1);
   endtask : cmd
   task automatic prg(logic [11:0] a, logic [31:0] d);
      int r0, b;
      r0 = prdy_n;
      b = (a == OFS_IRQ_ENABLE) ? 2 : 0;
      @(posedge clk_sys);
      #1 prg_req = '{1'b0, 1'b1, a, d};
      @(posedge clk_sys);
      #1 prg_req.wr = 1'b0;
      if (d[BIT_LO_MSK]) en_m[b] = d[BIT_LO_VAL];
      if (d[BIT_HI_MSK]) en_m[b + 1] = d[BIT_HI_VAL];
      repeat (2) @(posedge clk_sys);
      #1 check("prg_ready", prdy_n - r0, 1);
      check("host_if_en", host_if_en, en_m[0]);
      check("fe_if_en", fe_if_en, en_m[1]);
      check("prg_rdata", prg_rdata, {28'h0, en_m});
   endtask : prg
   task automatic exp_wr(logic [7:0] a, logic [15:0] d);
      expq.push_back({a, d});
      mdl[a] = d;
   endtask : exp_wr
   task automatic cmp_log;
      int i, n;
      n = i_cbi_far_model.wlog.size();
      check("write_count", n, expq.size());
      for (i = 0; i < expq.size() && i < n; i++) begin
         check("bus_write", i_cbi_far_model.wlog[i], expq[i]);
      end
      expq.delete();
      i_cbi_far_model.wlog.delete();
   endtask : cmp_log
   task automatic pulse(logic agc, logic sp);
      @(posedge clk_sys);
      #1 agc_irq_pin = agc;
      sp_irq_pin = sp;
      repeat (3) @(posedge clk_sys);
      #1 agc_irq_pin = 1'b0;
      sp_irq_pin = 1'b0;
      settle();
   endtask : pulse
   initial begin
      #(30000 * CLK_PERIOD_NS);
      err_total++;
      conclude();
   end
   initial begin
      int i, k, v, f0, len;
      logic [7:0] a;
      logic [3:0] nib;
      void'($urandom(41));
      for (i = 0; i < 256; i++) begin
         v = $urandom;
         mdl[i] = v[15:0];
         i_cbi_far_model.mem[i] = v[15:0];
      end
      en_m = 4'h0;
      repeat (3) @(posedge clk_sys);
      #1 resetn = 1'b1;
      // Single writes with garbage in the upper data half
      for (i = 0; i < 6; i++) begin
         a = 8'($urandom);
         v = $urandom;
         cmd(1'b0, 1'b1, {NIB_SINGLE, a}, v);
         exp_wr(a, v[15:0]);
      end
      cmp_log();
      for (i = 0; i < 6; i++) begin
         a = 8'($urandom);
         cmd(1'b1, 1'b0, {NIB_SINGLE, a}, 32'h0);
         check("cmd_rdata", cmd_rdata, {16'h0, mdl[a]});
      end
      // Burst write across the top of the register space
      for (i = 0; i < 5; i++) begin
         v = $urandom;
         i_cbi_far_model.h2bq.push_back(v);
         exp_wr(8'(8'hfe + i), v[15:0]);
      end
      cmd(1'b0, 1'b1, {NIB_BURST_WR, 8'hfe}, $urandom);
      cmp_log();
      check("h2b_left", i_cbi_far_model.h2bq.size(), 0);
      // Burst reads of every length with the host stalling
      slow = 1'b1;
      for (k = 0; k < 3; k++) begin
         nib = (k == 0) ? NIB_RD16 : (k == 1) ? NIB_RD64 : NIB_RD128;
         len = (k == 0) ? int'(LEN_RD16) : (k == 1) ? int'(LEN_RD64) : int'(LEN_RD128);
         a = 8'($urandom);
         cmd(1'b1, 1'b0, {nib, a}, 32'h0);
         check("b2h_count", i_cbi_far_model.b2hq.size(), len);
         for (i = 0; i < len && i < i_cbi_far_model.b2hq.size(); i++) begin
            check("b2h_word", i_cbi_far_model.b2hq[i], {16'h0, mdl[8'(a + i)]});
         end
         i_cbi_far_model.b2hq.delete();
         cmp_log();
      end
      slow = 1'b0;
      // Trigger only at its exact address
      f0 = fire_n;
      cmd(1'b0, 1'b1, FIRE_ADDR, $urandom);
      check("fire_pulse", fire_n - f0, 1);
      cmd(1'b0, 1'b1, 12'h455, $urandom);
      check("fire_other", fire_n - f0, 1);
      cmp_log();
      // Every value and mask combination at both offsets
      for (i = 0; i < 16; i++) prg(OFS_IF_ENABLE, i + ($urandom << 4));
      for (i = 0; i < 16; i++) prg(OFS_IRQ_ENABLE, i);
      // Program read is acknowledged and shows the enables
      f0 = prdy_n;
      @(posedge clk_sys);
      #1 prg_req = '{1'b1, 1'b0, OFS_IF_ENABLE, 32'h0000_0000};
      @(posedge clk_sys);
      #1 prg_req.rd = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 check("prg_rd_ready", prdy_n - f0, 1);
      check("prg_rd_data", prg_rdata, {28'h0, en_m});
      // Interrupt edges, disabled and enabled, each pin
      for (k = 0; k < 4; k++) begin
         prg(OFS_IRQ_ENABLE, k[0] ? 32'h0000_000f : 32'h0000_000a);
         pulse(!k[1], k[1]);
         if (k[0] && !k[1]) exp_wr(IRQ_AGC_ADDR, IRQ_AGC_DATA);
         if (k[0] && k[1]) exp_wr(IRQ_SP_ADDR, IRQ_SP_DATA);
         cmp_log();
      end
      // Both at once: gain write goes first
      pulse(1'b1, 1'b1);
      exp_wr(IRQ_AGC_ADDR, IRQ_AGC_DATA);
      exp_wr(IRQ_SP_ADDR, IRQ_SP_DATA);
      cmp_log();
      conclude();
   end
endmodule : tb_top
